/* cpc_charger_ctrl.sv */
`timescale 1ns/1ps
module cpc_charger_ctrl #(
	parameter int WAIT_CYC = cpc_pkg::CYC_WAIT,
	parameter int BLINK_HALF_CYC = cpc_pkg::CYC_BLINK_HALF,
	parameter int PULSE_MAX_CYC = cpc_pkg::CYC_PULSE_MAX,
	parameter int BURST_END_CYC = cpc_pkg::CYC_BURST_END,
	parameter int HIGH_OFF_CYC = cpc_pkg::CYC_HIGH_OFF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Comparator results
	input wire logic vin_input_undervoltage_lockout_ok,
	input wire logic vin_above_ovp,
	input wire logic bat_low,
	input wire logic bat_ovch,
	input wire logic bat_below_rec,
	input wire logic ts_cold,
	input wire logic ts_hot,
	input wire logic die_above_reg,
	input wire logic die_above_off,
	input wire logic die_below_off_hys,
	// Single control pin
	input wire logic ctrl_pin,
	// Open-drain charge status pin
	input wire logic chg_status_in,
	output logic chg_status_out,
	output logic chg_status_oe,
	// Power stage controls
	output logic ldo_en,
	output logic chg_switch_en,
	output logic precharge_sel,
	output logic thermal_throttle,
	output logic ts_sense_en,
	output logic quiescent_low,
	output logic [3:0] ilim_code,
	output logic [9:0] ilim_ma,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	localparam logic [20:0] P_WAIT = 21'(WAIT_CYC);
	localparam logic [20:0] P_BLINK = 21'(BLINK_HALF_CYC);
	localparam logic [20:0] P_DEGL = 21'(cpc_pkg::CYC_CTRL_DEGLITCH);
	localparam logic [11:0] P_OVP = 12'(cpc_pkg::CYC_OVP_DEGLITCH);

	typedef struct packed {
		cpc_pkg::cpc_state_t state;
		logic [20:0] tmr;
		logic [20:0] blink_cnt;
		logic blink;
		logic [11:0] ovp_cnt;
		logic ovp_trip;
		logic die_off;
		logic [3:0] ilim;
		logic last_valid;
		logic suspend;
		logic ts_en;
		logic served;
		logic [31:0] rdata;
	} cpc_ctl_t;

	cpc_ctl_t r;
	cpc_ctl_t next_r;
	cpc_ctl_t reset_r;

	logic charging;
	logic ts_fault;
	logic req;

	// ---------------------------------------------------------------
	// Pulse decoder
	// ---------------------------------------------------------------
	cpc_burst_if burst ();

	cpc_pulse_decoder #(
		.PULSE_MIN(cpc_pkg::CYC_PULSE_MIN),
		.PULSE_MAX(PULSE_MAX_CYC),
		.BURST_END(BURST_END_CYC),
		.HIGH_OFF(HIGH_OFF_CYC)
	) u_dec (
		.clk(clk),
		.resetn(resetn),
		.active(vin_input_undervoltage_lockout_ok),
		.ctrl_pin(ctrl_pin),
		.burst(burst.dec)
	);

	// ---------------------------------------------------------------
	// Control state
	// ---------------------------------------------------------------

	// Derived conditions
	assign charging = r.state == cpc_pkg::CPC_ST_PRECHG || r.state == cpc_pkg::CPC_ST_FAST;
	assign ts_fault = ts_cold || ts_hot;
	assign req = avs_read || avs_write;

	// Reset value of the state
	always_comb begin
		reset_r = '0;
		reset_r.state = cpc_pkg::CPC_ST_DISABLED;
		reset_r.ilim = cpc_pkg::ILIM_DEFAULT;
		reset_r.suspend = cpc_pkg::CONTROL_RESET;
		reset_r.ts_en = 1'b1;
	end

	// Next state: sequencing, protections, burst decode and register access
	always_comb begin
		next_r = r;
		// Charge sequence
		case (r.state)
			cpc_pkg::CPC_ST_DISABLED: begin
				next_r.tmr = ctrl_pin ? 21'h000000 : r.tmr + 21'h000001;
				if (!ctrl_pin && r.tmr == P_DEGL - 21'h000001) begin
					next_r.state = cpc_pkg::CPC_ST_WAIT;
					next_r.tmr = 21'h000000;
				end
			end
			cpc_pkg::CPC_ST_WAIT: begin
				next_r.tmr = r.tmr + 21'h000001;
				if (r.tmr == P_WAIT - 21'h000001)
					next_r.state = bat_low ? cpc_pkg::CPC_ST_PRECHG
						: cpc_pkg::CPC_ST_FAST;
			end
			cpc_pkg::CPC_ST_PRECHG: begin
				if (!bat_low)
					next_r.state = cpc_pkg::CPC_ST_FAST;
			end
			cpc_pkg::CPC_ST_FAST: begin
				if (bat_ovch)
					next_r.state = cpc_pkg::CPC_ST_FLOAT;
			end
			cpc_pkg::CPC_ST_FLOAT: begin
				if (bat_below_rec)
					next_r.state = bat_low ? cpc_pkg::CPC_ST_PRECHG
						: cpc_pkg::CPC_ST_FAST;
			end
			default: next_r.state = cpc_pkg::CPC_ST_DISABLED;
		endcase
		if (burst.high_long) begin
			next_r.state = cpc_pkg::CPC_ST_DISABLED;
			next_r.tmr = 21'h000000;
		end
		// Burst decode
		if (burst.done) begin
			next_r.last_valid = burst.valid;
			if (burst.valid && burst.count >= cpc_pkg::PULSES_FIRST
					&& burst.count <= cpc_pkg::PULSES_LAST)
				next_r.ilim = 4'(burst.count - cpc_pkg::PULSES_FIRST);
		end
		// Overvoltage deglitch
		if (vin_above_ovp) begin
			if (r.ovp_cnt != P_OVP)
				next_r.ovp_cnt = r.ovp_cnt + 12'h001;
			if (r.ovp_cnt == P_OVP - 12'h001)
				next_r.ovp_trip = 1'b1;
		end else begin
			next_r.ovp_cnt = 12'h000;
			next_r.ovp_trip = 1'b0;
		end
		// Die shutdown with hysteresis
		if (die_above_off)
			next_r.die_off = 1'b1;
		else if (die_below_off_hys)
			next_r.die_off = 1'b0;
		// Temperature fault blink timer
		if (charging && ts_fault) begin
			next_r.blink_cnt = r.blink_cnt + 21'h000001;
			if (r.blink_cnt == P_BLINK - 21'h000001) begin
				next_r.blink_cnt = 21'h000000;
				next_r.blink = !r.blink;
			end
		end else begin
			next_r.blink_cnt = 21'h000000;
			next_r.blink = 1'b0;
		end
		// Register access: capture in first cycle, answer in second
		next_r.served = req && !r.served;
		if (req && !r.served) begin
			if (avs_address == cpc_pkg::REG_STATUS)
				next_r.rdata = {20'h00000, r.last_valid, r.die_off, r.ovp_trip,
					ts_fault, r.ilim, 1'b0, r.state};
			else if (avs_address == cpc_pkg::REG_CONTROL)
				next_r.rdata = {31'h00000000, r.suspend};
			else
				next_r.rdata = 32'h00000000;
		end
		if (avs_write && r.served && avs_address == cpc_pkg::REG_CONTROL)
			next_r.suspend = avs_writedata[cpc_pkg::CONTROL_SUSPEND_BIT];
		// Undervoltage holds the rest at reset, keeping suspend and bus access; status pin gates sense
		next_r.ts_en = 1'b1;
		if (!vin_input_undervoltage_lockout_ok) begin
			next_r = reset_r;
			next_r.suspend = r.suspend;
			next_r.served = req && !r.served;
			next_r.rdata = r.rdata;
			next_r.ts_en = chg_status_in;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn)
			r <= reset_r;
		else
			r <= next_r;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------

	// Power stage and status pin
	assign ldo_en = vin_input_undervoltage_lockout_ok && !r.ovp_trip;
	assign chg_switch_en = vin_input_undervoltage_lockout_ok && !r.ovp_trip && !r.die_off && !r.suspend
		&& (charging || r.state == cpc_pkg::CPC_ST_FLOAT) && !ts_fault;
	assign chg_status_out = 1'b0;
	assign chg_status_oe = vin_input_undervoltage_lockout_ok && charging && !(ts_fault && r.blink);
	assign precharge_sel = r.state == cpc_pkg::CPC_ST_PRECHG;
	assign thermal_throttle = chg_switch_en && die_above_reg;
	assign ts_sense_en = r.ts_en;
	assign quiescent_low = r.state == cpc_pkg::CPC_ST_DISABLED;
	assign ilim_code = r.ilim;
	assign ilim_ma = cpc_pkg::cpc_ilim_ma(r.ilim);
	// Bus answer
	assign avs_readdata = r.rdata;
	assign avs_waitrequest = req && !r.served;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_enable_low;
		r.state == cpc_pkg::CPC_ST_DISABLED && !ctrl_pin && r.tmr == P_DEGL - 21'h000001
			&& vin_input_undervoltage_lockout_ok && !burst.high_long;
	endsequence

	sequence s_wait_end;
		r.state == cpc_pkg::CPC_ST_WAIT && r.tmr == P_WAIT - 21'h000001
			&& vin_input_undervoltage_lockout_ok && !burst.high_long;
	endsequence

	a_input_undervoltage_lockout_all_off: assert property (!vin_input_undervoltage_lockout_ok |->
		!ldo_en && !chg_switch_en && !chg_status_oe)
		else $error("undervoltage left outputs active");
	a_input_undervoltage_lockout_state_clear: assert property (!vin_input_undervoltage_lockout_ok |=> r.state == cpc_pkg::CPC_ST_DISABLED)
		else $error("undervoltage did not clear state");
	a_ts_suspend: assert property (ts_fault |-> !chg_switch_en)
		else $error("switch on during temperature fault");
	a_ts_keep_low: assert property (vin_input_undervoltage_lockout_ok && charging && ts_fault && !r.blink
		|-> chg_status_oe)
		else $error("status released in fault low phase");
	a_blink_toggle: assert property (charging && ts_fault && r.blink_cnt == P_BLINK - 21'h000001
		&& vin_input_undervoltage_lockout_ok && !burst.high_long |=> r.blink != $past(r.blink))
		else $error("blink did not toggle at half period");
	a_ldo_free: assert property (vin_input_undervoltage_lockout_ok && !r.ovp_trip |-> ldo_en)
		else $error("aux supply off inside window");
	a_float_release: assert property (r.state == cpc_pkg::CPC_ST_FLOAT |-> !chg_status_oe)
		else $error("status driven after overcharge");
	a_recharge_low: assert property (r.state == cpc_pkg::CPC_ST_FLOAT && bat_below_rec
		&& vin_input_undervoltage_lockout_ok && !burst.high_long |=> charging)
		else $error("recharge did not restart charging");
	a_enable_wait: assert property (s_enable_low |=> r.state == cpc_pkg::CPC_ST_WAIT)
		else $error("deglitch did not enter wait");
	a_wait_start: assert property (s_wait_end |=> charging ##0
		(precharge_sel == $past(bat_low)))
		else $error("wait end did not choose stage");
	a_decode_four: assert property (burst.done && burst.valid && burst.count == 5'h04
		&& vin_input_undervoltage_lockout_ok |=> ilim_code == 4'h0 && ilim_ma == 10'd93)
		else $error("four pulses not decoded");
	a_high_off: assert property (burst.high_long && vin_input_undervoltage_lockout_ok
		|=> r.state == cpc_pkg::CPC_ST_DISABLED)
		else $error("long high did not disable");
	a_die_off: assert property (die_above_off |=> !chg_switch_en)
		else $error("switch on above die shutdown");
	a_ovp_off: assert property (vin_above_ovp [*8] ##1 (r.ovp_cnt == P_OVP) |-> !ldo_en)
		else $error("overvoltage left supply on");

endmodule : cpc_charger_ctrl

/* cpc_pkg.sv */
package cpc_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int T_CTRL_DEGLITCH_US = 50;
	localparam int T_WAIT_MS = 32;
	localparam int T_PULSE_MIN_US = 50;
	localparam int T_PULSE_MAX_US = 1000;
	localparam int T_BURST_END_MS = 2;
	localparam int T_HIGH_OFF_MS = 2;
	localparam int T_OVP_DEGLITCH_US = 115;
	localparam int T_BLINK_PERIOD_MS = 100;
	// Least times round up, longest times round down
	localparam int CYC_CTRL_DEGLITCH = (T_CTRL_DEGLITCH_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int CYC_WAIT = T_WAIT_MS * (CLK_HZ / 1000);
	localparam int CYC_PULSE_MIN = (T_PULSE_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int CYC_PULSE_MAX = (T_PULSE_MAX_US * (CLK_HZ / 1000)) / 1000;
	localparam int CYC_BURST_END = T_BURST_END_MS * (CLK_HZ / 1000);
	localparam int CYC_HIGH_OFF = T_HIGH_OFF_MS * (CLK_HZ / 1000);
	localparam int CYC_OVP_DEGLITCH = (T_OVP_DEGLITCH_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int CYC_BLINK_HALF = (T_BLINK_PERIOD_MS * (CLK_HZ / 1000)) / 2;

	// ---------------------------------------------------------------
	// Pulse decode
	// ---------------------------------------------------------------
	localparam logic [4:0] PULSES_FIRST = 5'h04;
	localparam logic [4:0] PULSES_LAST = 5'h0b;
	localparam logic [3:0] ILIM_DEFAULT = 4'h8;

	// ---------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CONTROL = 4'h4;
	localparam int CONTROL_SUSPEND_BIT = 0;
	localparam logic CONTROL_RESET = 1'b0;

	typedef enum logic [2:0] {
		CPC_ST_DISABLED = 3'h0,
		CPC_ST_WAIT = 3'h1,
		CPC_ST_PRECHG = 3'h2,
		CPC_ST_FAST = 3'h3,
		CPC_ST_FLOAT = 3'h4
	} cpc_state_t;

	// Current limit in mA for each code
	function automatic logic [9:0] cpc_ilim_ma(input logic [3:0] code);
		case (code)
			4'h0: cpc_ilim_ma = 10'd93;
			4'h1: cpc_ilim_ma = 10'd187;
			4'h2: cpc_ilim_ma = 10'd280;
			4'h3: cpc_ilim_ma = 10'd374;
			4'h4: cpc_ilim_ma = 10'd467;
			4'h5: cpc_ilim_ma = 10'd654;
			4'h6: cpc_ilim_ma = 10'd794;
			4'h7: cpc_ilim_ma = 10'd935;
			default: cpc_ilim_ma = 10'd285;
		endcase
	endfunction : cpc_ilim_ma

endpackage : cpc_pkg

/* cpc_burst_if.sv */
`timescale 1ns/1ps
interface cpc_burst_if;
	logic done;
	logic [4:0] count;
	logic valid;
	logic high_long;
	modport dec (output done, output count, output valid, output high_long);
	modport ctl (input done, input count, input valid, input high_long);
endinterface : cpc_burst_if

/* cpc_pulse_decoder.sv */
`timescale 1ns/1ps
module cpc_pulse_decoder #(
	parameter int PULSE_MIN = cpc_pkg::CYC_PULSE_MIN,
	parameter int PULSE_MAX = cpc_pkg::CYC_PULSE_MAX,
	parameter int BURST_END = cpc_pkg::CYC_BURST_END,
	parameter int HIGH_OFF = cpc_pkg::CYC_HIGH_OFF
) (
	// Clock and clear
	input wire logic clk,
	input wire logic resetn,
	input wire logic active,
	// Control pin level
	input wire logic ctrl_pin,
	// Burst results
	cpc_burst_if.dec burst
);

	localparam logic [15:0] P_MIN = 16'(PULSE_MIN);
	localparam logic [15:0] P_MAX = 16'(PULSE_MAX);
	localparam logic [15:0] P_END = 16'(BURST_END);
	localparam logic [15:0] P_OFF = 16'(HIGH_OFF);

	typedef struct packed {
		logic prev;
		logic [15:0] hi_cnt;
		logic [15:0] lo_cnt;
		logic [4:0] pulses;
		logic bad;
		logic busy;
		logic done;
		logic [4:0] count;
		logic valid;
	} cpc_dec_t;

	cpc_dec_t r;
	cpc_dec_t next_r;

	// Measure pulse widths and gaps, count pulses, close burst after long low
	always_comb begin
		next_r = r;
		next_r.prev = ctrl_pin;
		next_r.done = 1'b0;
		if (ctrl_pin) begin
			if (r.hi_cnt != 16'hffff)
				next_r.hi_cnt = r.hi_cnt + 16'h0001;
			if (!r.prev) begin
				next_r.hi_cnt = 16'h0001;
				if (r.busy && (r.lo_cnt < P_MIN || r.lo_cnt > P_MAX))
					next_r.bad = 1'b1;
			end
		end else begin
			if (r.lo_cnt != 16'hffff)
				next_r.lo_cnt = r.lo_cnt + 16'h0001;
			if (r.prev) begin
				next_r.lo_cnt = 16'h0001;
				// Long high outside a burst is the idle level: the enable edge is no pulse
				if (r.busy || r.hi_cnt <= P_MAX) begin
					if (r.hi_cnt < P_MIN || r.hi_cnt > P_MAX)
						next_r.bad = 1'b1;
					if (r.pulses != 5'h1f)
						next_r.pulses = r.pulses + 5'h01;
					next_r.busy = 1'b1;
				end
			end else if (r.busy && r.lo_cnt == P_END - 16'h0001) begin
				next_r.done = 1'b1;
				next_r.count = r.pulses;
				next_r.valid = !r.bad;
				next_r.busy = 1'b0;
				next_r.bad = 1'b0;
				next_r.pulses = 5'h00;
			end
		end
		if (!active)
			next_r = '0;
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign burst.done = r.done;
	assign burst.count = r.count;
	assign burst.valid = r.valid;
	assign burst.high_long = r.prev && r.hi_cnt > P_OFF;

	a_bad_burst: assert property (@(posedge clk) disable iff (!resetn)
		(active && r.prev && !ctrl_pin && (r.hi_cnt < P_MIN)) |=> r.bad)
		else $error("short pulse did not spoil burst");

endmodule : cpc_pulse_decoder

/* cpc_host_model.sv */
`timescale 1ns/1ps
// Host side: drives the control pin and may hold the status wire low
module cpc_host_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic ctrl_pin,
	output logic host_pull
);
	// Idle host: pin high, status wire left to its pull-up
	initial begin
		ctrl_pin = 1'b1;
		host_pull = 1'b0;
	end
	// Hold the pin at one level for n cycles, called just after an edge
	task automatic hold(input logic lvl, input int n);
		ctrl_pin <= lvl;
		repeat (n) @(posedge clk);
	endtask : hold
	// Burst of n pulses with given high and low times
	task automatic burst(input int n, input int hi, input int lo);
		for (int i = 0; i < n; i++) begin
			hold(1'b1, hi);
			hold(1'b0, lo);
		end
	endtask : burst
	// Hold the status wire low from outside, or let it go
	task automatic pull(input logic lvl);
		host_pull <= lvl;
	endtask : pull
endmodule : cpc_host_model

/* test_charger_pulse_control.sv */
`timescale 1ns/1ps
module test_charger_pulse_control;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int HOFF = 3000;
	localparam int PW = 1260;
	typedef struct {int n; logic [3:0] code; logic [9:0] ma;} cpc_row_t;
	cpc_row_t rows [3] = '{'{4, 4'h0, 10'h05d}, '{12, 4'h0, 10'h05d}, '{9, 4'h5, 10'h28e}};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic vin_input_undervoltage_lockout_ok = 1'b1, vin_above_ovp = 1'b0, bat_low = 1'b0, bat_ovch = 1'b0;
	logic bat_below_rec = 1'b0, ts_cold = 1'b0, ts_hot = 1'b0;
	logic die_above_reg = 1'b0, die_above_off = 1'b0, die_below_off_hys = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic ctrl_pin, host_pull, chg_wire, chg_status_out, chg_status_oe, ldo_en, chg_switch_en;
	logic precharge_sel, thermal_throttle, ts_sense_en, quiescent_low, avs_waitrequest;
	logic [3:0] ilim_code;
	logic [9:0] ilim_ma;
	int fails = 0, n_checks = 0, cycles = 0, hi_cnt;

	// Clock and the pulled-up status wire
	always #20 clk = ~clk;
	assign chg_wire = (chg_status_oe ? chg_status_out : 1'b1) & ~host_pull;

	// ---------------------------------------------------------------
	// Instances
	// ---------------------------------------------------------------
	cpc_host_model HOST (.clk(clk), .ctrl_pin(ctrl_pin), .host_pull(host_pull));
	cpc_charger_ctrl #(.WAIT_CYC(200), .BLINK_HALF_CYC(50), .PULSE_MAX_CYC(2000),
		.BURST_END_CYC(HOFF), .HIGH_OFF_CYC(HOFF)) DUT (.clk, .resetn, .vin_input_undervoltage_lockout_ok,
		.vin_above_ovp, .bat_low, .bat_ovch, .bat_below_rec, .ts_cold, .ts_hot, .die_above_reg,
		.die_above_off, .die_below_off_hys, .ctrl_pin, .chg_status_in(chg_wire),
		.chg_status_out, .chg_status_oe, .ldo_en, .chg_switch_en, .precharge_sel,
		.thermal_throttle, .ts_sense_en, .quiescent_low, .ilim_code, .ilim_ma, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic chk1(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %b", $time, what, got);
		end
	endtask : chk1
	task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chkv
	// One bus cycle, held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 99000) begin
			fails++;
			$display("BAD %0t run too long", $time);
			stop_test();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		cyc(2);
		resetn <= 1'b1;
		cyc(1);
		chk1(quiescent_low, 1'b1, "quiescent after reset");
		bus(1'b0, 4'h0, 32'h0, rd);
		chkv(rd, 32'h80, "status after reset");
		// Idle high beyond the longest pulse, then enable with a low battery
		HOST.hold(1'b1, 2100);
		bat_low <= 1'b1;
		HOST.hold(1'b0, 1000);
		chk1(quiescent_low, 1'b1, "left disabled early");
		cyc(500);
		chk1(precharge_sel, 1'b1, "precharge");
		chk1(chg_status_oe, 1'b1, "status low in precharge");
		chk1(chg_status_out, 1'b0, "status drives low level");
		chkv({22'h0, ilim_ma}, 32'h11d, "default limit");
		bat_low <= 1'b0;
		cyc(3);
		bus(1'b0, 4'h0, 32'h0, rd);
		chkv(rd, 32'h83, "fast charge state");
		// Pulse bursts from the table
		foreach (rows[i]) begin
			HOST.burst(rows[i].n, PW, PW);
			cyc(HOFF + 10 - PW);
			chkv({28'h0, ilim_code}, {28'h0, rows[i].code}, "limit code");
			chkv({22'h0, ilim_ma}, {22'h0, rows[i].ma}, "limit mA");
		end
		// Short first pulse spoils an otherwise valid burst
		HOST.burst(1, 600, PW);
		HOST.burst(4, PW, PW);
		cyc(HOFF + 10 - PW);
		chkv({28'h0, ilim_code}, 32'h5, "spoiled burst");
		// Pack temperature fault: suspend, blink, resume
		ts_hot <= 1'b1;
		cyc(4);
		chk1(chg_switch_en, 1'b0, "hot suspend");
		hi_cnt = 0;
		repeat (200) begin
			@(posedge clk);
			hi_cnt += int'(chg_status_oe === 1'b1);
		end
		chkv(hi_cnt, 32'd100, "blink duty");
		ts_hot <= 1'b0;
		ts_cold <= 1'b1;
		cyc(4);
		chk1(chg_switch_en, 1'b0, "cold suspend");
		ts_cold <= 1'b0;
		cyc(4);
		chk1(chg_switch_en, 1'b1, "resume");
		chk1(chg_status_oe, 1'b1, "status low again");
		// Overcharge, float, recharge
		bat_ovch <= 1'b1;
		cyc(4);
		chk1(chg_status_oe, 1'b0, "released at overcharge");
		chk1(chg_switch_en, 1'b1, "float keeps switch");
		bat_ovch <= 1'b0;
		bat_below_rec <= 1'b1;
		cyc(4);
		chk1(chg_status_oe, 1'b1, "recharge start");
		bat_below_rec <= 1'b0;
		// Die temperature throttle and shutdown with hysteresis
		die_above_reg <= 1'b1;
		cyc(3);
		chk1(thermal_throttle, 1'b1, "throttle");
		die_above_off <= 1'b1;
		cyc(3);
		chk1(chg_switch_en, 1'b0, "die off");
		die_above_off <= 1'b0;
		cyc(3);
		chk1(chg_switch_en, 1'b0, "inside hysteresis");
		die_below_off_hys <= 1'b1;
		cyc(3);
		chk1(chg_switch_en, 1'b1, "die on again");
		die_above_reg <= 1'b0;
		die_below_off_hys <= 1'b0;
		// Suspend through the register, unmapped address reads zero
		bus(1'b1, 4'h4, 32'h1, rd);
		cyc(2);
		chk1(chg_switch_en, 1'b0, "soft suspend");
		bus(1'b0, 4'h4, 32'h0, rd);
		chkv(rd, 32'h1, "control readback");
		bus(1'b0, 4'h8, 32'h0, rd);
		chkv(rd, 32'h0, "unmapped read");
		bus(1'b1, 4'h4, 32'h0, rd);
		// Overvoltage after its deglitch
		vin_above_ovp <= 1'b1;
		cyc(2000);
		chk1(ldo_en, 1'b1, "within deglitch");
		cyc(1000);
		chk1(ldo_en, 1'b0, "overvoltage aux off");
		chk1(chg_switch_en, 1'b0, "overvoltage charge off");
		vin_above_ovp <= 1'b0;
		cyc(3);
		chk1(ldo_en, 1'b1, "aux back");
		// Pin held high disables
		HOST.hold(1'b1, HOFF + 10);
		chk1(quiescent_low, 1'b1, "disabled");
		chk1(chg_switch_en, 1'b0, "disabled switch");
		// Undervoltage ignores a low pin; status wire gates sensing
		HOST.hold(1'b0, 2);
		vin_input_undervoltage_lockout_ok <= 1'b0;
		cyc(1500);
		chk1(ldo_en, 1'b0, "lockout aux");
		chk1(chg_status_oe, 1'b0, "lockout status");
		chk1(chg_switch_en, 1'b0, "lockout switch");
		chk1(quiescent_low, 1'b1, "pin ignored");
		HOST.pull(1'b1);
		cyc(3);
		chk1(ts_sense_en, 1'b0, "sense off");
		HOST.pull(1'b0);
		cyc(3);
		chk1(ts_sense_en, 1'b1, "sense on");
		stop_test();
	end
endmodule : test_charger_pulse_control
